// [verilog/debug_link_defines.svh]
/*
 * timing counts and field constants for the one-pin debug serial link.
 * assumes a 20 mhz system clock; included by the serial link module.
 */
// Notes on behaviour
// - one shared open-drain pin, half duplex, never both ends sending.
// - characters are start low, eight data bits lsb first, stop high.
// - idle after reset until data; first host character must be 80h.
// - measure sync low period in clocks, program bit period from it.
// - runs on system clock; slowest rate is clock over 512.
// - nine or more low bit times is a break; relearn rate afterwards.
// - a low sampled stop bit is a framing error.
// - while sending, a line level unlike the sent bit is a collision.
// - on any error abort, send 4096-cycle low break, reset baud logic.
// - host break resets baud logic only; control bit and mode stay. here it is handled as an error: 4096-cycle break back, transmit queue flushed.
// - debugger logic held in reset while break lasts, until pin high.
// - in debug mode instruction fetch stops except directed ones.
// - clock and peripherals run; halt exits; watchdog kept refreshed.
// - writing debug mode bit to one enters debug mode.
// - an executed breakpoint instruction enters debug mode.
// - enabled pc match or counter reaching zero enters debug mode.
// - debug pin low when leaving reset enters debug mode.
// - clearing the bit, power-on, brown-out or reset pin exits.
// - debug pin low during stop mode starts a system reset.
`ifndef DEBUG_LINK_DEFINES_SVH
`define DEBUG_LINK_DEFINES_SVH
`define SYS_CLK_HZ 20000000
`define SYNC_CHAR 8'h80
`define SYNC_LOW_BITS 8
`define SYNC_SHIFT 3
`define MAX_DIV 512
`define BIT_CNT_W 13
`define BREAK_BITS 9
`define ERR_BREAK_CYCLES 4096
`define TX_BREAK_CYCLES 13'h1000
`define FIFO_DEPTH 4
`define DATA_W 8
`endif

// [verilog/debug_link_pkg.sv]
/*
 * types shared by the debug link modules.
 * assumes the defines header is included before use.
 */
package debug_link_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [2:0] {
		L_IDLE = 3'b000,
		L_SYNC = 3'b001,
		L_READY = 3'b011,
		L_RX = 3'b010,
		L_TX = 3'b110,
		L_BREAK = 3'b111,
		L_WAITHI = 3'b101
	} link_state_e;
endpackage

// [verilog/debug_byte_fifo.sv]
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and an active-high asynchronous reset.
 */
`timescale 1ns/1ps
module debug_byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic flush_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid_out && out_ready_in;
	// honest full and empty from the fill count
	assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out = mem_q[rd_q];
	// pointer and count update
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else if (flush_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
	// storage
	always_ff @(posedge clk_in) begin
		if (push)
			mem_q[wr_q] <= in_data_in;
	end
endmodule

// [verilog/debug_mode_ctrl.sv]
/*
 * debug mode flag: entry and exit conditions, one mode flag output.
 * assumes the device resets arrive as synchronous one-cycle pulses.
 */
`timescale 1ns/1ps
module debug_mode_ctrl (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic entry_pin_low_in,
	input wire logic set_req_in,
	input wire logic clr_req_in,
	input wire logic brk_exec_in,
	input wire logic pc_match_en_in,
	input wire logic [15:0] pc_in,
	input wire logic [15:0] cntr_in,
	input wire logic cntr_zero_en_in,
	input wire logic cntr_dec_in,
	input wire logic dev_reset_in,
	output logic debug_mode_out
);
	logic mode_q;
	logic mode_d;
	logic first_q;
	wire pc_hit = pc_match_en_in && (pc_in == cntr_in);
	wire cnt_hit = cntr_zero_en_in && cntr_dec_in && (cntr_in == 16'h0001);
	wire enter = set_req_in || brk_exec_in || pc_hit || cnt_hit;
	// exit on device reset first, entry wins over clear
	always_comb begin
		mode_d = mode_q;
		if (dev_reset_in)
			mode_d = 1'b0;
		else if (enter)
			mode_d = 1'b1;
		else if (clr_req_in)
			mode_d = 1'b0;
		// strap caught on first edge after release
		if (first_q && entry_pin_low_in)
			mode_d = 1'b1;
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_q <= 1'b0;
			first_q <= 1'b1;
		end else begin
			mode_q <= mode_d;
			first_q <= dev_reset_in;
		end
	end
	assign debug_mode_out = mode_q;
	// entry and exit checks on the mode flag
	property p_mode_enter;
		@(posedge clk_in) disable iff (rst_in)
		(brk_exec_in && !dev_reset_in) |=> mode_q;
	endproperty
	a_mode_enter: assert property (p_mode_enter)
		else $error("breakpoint did not enter debug mode");
	property p_mode_exit;
		@(posedge clk_in) disable iff (rst_in)
		(dev_reset_in && !entry_pin_low_in) |=> !mode_q;
	endproperty
	a_mode_exit: assert property (p_mode_exit)
		else $error("device reset did not leave debug mode");
endmodule

// [verilog/debug_serial_link.sv]
/*
 * one-pin debug serial link: autobaud, receive, transmit, break
 * handling, and debug mode outputs toward the processor.
 * assumes the pin input is synchronous and pulled high outside.
 */
`timescale 1ns/1ps
`include "debug_link_defines.svh"
module debug_serial_link (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic debug_serial_pin_in,
	output logic debug_serial_pin_out,
	output logic debug_serial_pin_oe_out,
	output logic [7:0] rx_data_out,
	output logic rx_valid_out,
	input wire logic rx_ready_in,
	input wire debug_link_pkg::byte_t tx_data_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic error_out,
	output logic baud_locked_out,
	input wire logic set_mode_in,
	input wire logic clr_mode_in,
	input wire logic breakpoint_instruction_in,
	input wire logic pc_match_en_in,
	input wire logic [15:0] pc_in,
	input wire logic [15:0] debug_multi_counter_in,
	input wire logic cntr_zero_en_in,
	input wire logic cntr_dec_in,
	input wire logic dev_reset_in,
	input wire logic stop_mode_in,
	output logic debug_mode_out,
	output logic fetch_stop_out,
	output logic halt_exit_out,
	output logic wdt_refresh_out,
	output logic sys_reset_req_out
);
	import debug_link_pkg::*;
	localparam int CW = `BIT_CNT_W;
	link_state_e state_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] period_q;
	logic [3:0] bit_q;
	logic [8:0] shift_q;
	logic [CW-1:0] low_q;
	logic tx_bit_q;
	logic err_q;
	logic rxv_q;
	logic drive_q;
	logic mode_w;
	logic fifo_valid;
	logic [7:0] fifo_data;
	logic tx_pop;
	logic fifo_in_ready;
	logic rx_push;
	// bit period helpers
	function automatic logic [CW-1:0] half(input logic [CW-1:0] p);
		return {1'b0, p[CW-1:1]};
	endfunction
	wire line_hi = debug_serial_pin_in;
	wire bit_end = (cnt_q == period_q - 1'b1);
	// break is nine bit times low, counted in cycles
	wire [CW+3:0] break_len = (CW+4)'(period_q) * (CW+4)'(`BREAK_BITS);
	// own low bits while sending a zero byte must not look like a break
	wire brk_seen = (period_q != '0) && !line_hi && (state_q != L_TX) &&
		((CW+4)'(low_q) >= break_len - 1'b1);
	// collision while sending a high bit
	wire collide = (state_q == L_TX) && tx_bit_q && !line_hi &&
		(cnt_q == half(period_q));
	wire frame_err = (state_q == L_RX) && (bit_q == 4'd9) &&
		(cnt_q == half(period_q)) && !line_hi;
	wire any_err = brk_seen || collide || frame_err;
	// low run length for break detection
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			low_q <= '0;
		else if (line_hi)
			low_q <= '0;
		else if (low_q != '1)
			low_q <= low_q + 1'b1;
	end
	// link state machine
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q <= L_IDLE;
			cnt_q <= '0;
			period_q <= '0;
			bit_q <= '0;
			shift_q <= '0;
			tx_bit_q <= 1'b1;
			err_q <= 1'b0;
			rxv_q <= 1'b0;
		end else begin
			err_q <= 1'b0;
			rxv_q <= 1'b0;
			if (any_err && state_q != L_BREAK && state_q != L_WAITHI &&
				state_q != L_IDLE && state_q != L_SYNC) begin
				state_q <= L_BREAK;
				cnt_q <= '0;
				period_q <= '0;
				tx_bit_q <= 1'b0;
				err_q <= 1'b1;
			end else begin
				case (state_q)
				L_IDLE: begin
					tx_bit_q <= 1'b1;
					cnt_q <= '0;
					if (!line_hi)
						state_q <= L_SYNC;
				end
				// measure eight low bits of the sync character
				L_SYNC: begin
					if (!line_hi) begin
						if (cnt_q == CW'(`MAX_DIV * `SYNC_LOW_BITS - 1))
							state_q <= L_WAITHI;
						else
							cnt_q <= cnt_q + 1'b1;
					end else begin
						// period bounded by the 512 divider
						period_q <= (cnt_q + 1'b1) >> `SYNC_SHIFT;
						state_q <= L_READY;
						cnt_q <= '0;
					end
				end
				L_READY: begin
					cnt_q <= '0;
					bit_q <= '0;
					if (!line_hi) begin
						state_q <= L_RX;
					end else if (fifo_valid) begin
						shift_q <= {1'b1, fifo_data};
						tx_bit_q <= 1'b0;
						state_q <= L_TX;
					end
				end
				L_RX: begin
					cnt_q <= bit_end ? '0 : cnt_q + 1'b1;
					if (cnt_q == half(period_q)) begin
						if (bit_q == 4'd0 && line_hi)
							state_q <= L_READY;
						else if (bit_q != 4'd0 && bit_q != 4'd9)
							shift_q <= {1'b0, line_hi, shift_q[7:1]};
						if (bit_q == 4'd9) begin
							rxv_q <= 1'b1;
							state_q <= L_READY;
						end
						bit_q <= bit_q + 1'b1;
					end
				end
				L_TX: begin
					cnt_q <= bit_end ? '0 : cnt_q + 1'b1;
					if (bit_end) begin
						bit_q <= bit_q + 1'b1;
						if (bit_q == 4'd9) begin
							tx_bit_q <= 1'b1;
							state_q <= L_READY;
						end else begin
							tx_bit_q <= shift_q[0];
							shift_q <= {1'b1, shift_q[8:1]};
						end
					end
				end
				// fixed-length low break back to host
				L_BREAK: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q == `TX_BREAK_CYCLES - 1'b1) begin
						tx_bit_q <= 1'b1;
						state_q <= L_WAITHI;
					end
				end
				// held in reset until the pin returns high
				L_WAITHI: begin
					tx_bit_q <= 1'b1;
					period_q <= '0;
					cnt_q <= '0;
					if (line_hi)
						state_q <= L_IDLE;
				end
				default: state_q <= L_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			drive_q <= 1'b0;
		else
			drive_q <= (state_q == L_TX || state_q == L_BREAK) ?
				!tx_bit_q : 1'b0;
	end
	assign debug_serial_pin_out = 1'b0;
	assign debug_serial_pin_oe_out = drive_q;
	assign tx_pop = (state_q == L_READY) && line_hi && fifo_valid &&
		!any_err;
	assign rx_push = rxv_q;
	// transmit queue toward the line
	debug_byte_fifo #(.WIDTH(`DATA_W), .DEPTH(`FIFO_DEPTH)) u_txq (
		.clk_in(ref_clk_in),
		.rst_in(rst_in),
		.flush_in(err_q),
		.in_valid_in(tx_valid_in),
		.in_ready_out(fifo_in_ready),
		.in_data_in(tx_data_in),
		.out_valid_out(fifo_valid),
		.out_ready_in(tx_pop),
		.out_data_out(fifo_data)
	);
	// mode flag is outside the baud reset path
	debug_mode_ctrl u_mode (
		.clk_in(ref_clk_in),
		.rst_in(rst_in),
		.entry_pin_low_in(!debug_serial_pin_in),
		.set_req_in(set_mode_in),
		.clr_req_in(clr_mode_in),
		.brk_exec_in(breakpoint_instruction_in),
		.pc_match_en_in(pc_match_en_in),
		.pc_in(pc_in),
		.cntr_in(debug_multi_counter_in),
		.cntr_zero_en_in(cntr_zero_en_in),
		.cntr_dec_in(cntr_dec_in),
		.dev_reset_in(dev_reset_in),
		.debug_mode_out(mode_w)
	);
	// registered outputs toward user and processor
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rx_data_out <= '0;
			rx_valid_out <= 1'b0;
			tx_ready_out <= 1'b0;
			error_out <= 1'b0;
			baud_locked_out <= 1'b0;
			debug_mode_out <= 1'b0;
			fetch_stop_out <= 1'b0;
			halt_exit_out <= 1'b0;
			wdt_refresh_out <= 1'b0;
			sys_reset_req_out <= 1'b0;
		end else begin
			if (rx_push)
				rx_data_out <= shift_q[7:0];
			if (rx_push)
				rx_valid_out <= 1'b1;
			else if (rx_ready_in)
				rx_valid_out <= 1'b0;
			tx_ready_out <= fifo_in_ready;
			error_out <= err_q;
			baud_locked_out <= (period_q != '0);
			debug_mode_out <= mode_w;
			// hold processor fetch, keep it awake
			fetch_stop_out <= mode_w;
			halt_exit_out <= mode_w;
			wdt_refresh_out <= mode_w;
			// pin low in stop mode asks for system reset
			sys_reset_req_out <= stop_mode_in && !debug_serial_pin_in;
		end
	end
	// checks on the link state machine, the pin driver, the queue flush and the stop reset request
	// break return: entry into the break state, then it holds
	sequence s_break_enter;
		$rose(state_q == L_BREAK);
	endsequence
	sequence s_break_hold;
		(state_q == L_BREAK)[*8];
	endsequence
	property p_break_len;
		@(posedge ref_clk_in) disable iff (rst_in)
		s_break_enter |-> s_break_hold;
	endproperty
	a_break_len: assert property (p_break_len)
		else $error("error break ended early");
	// cycles spent in the returned break, for the length check
	logic [CW-1:0] brk_run_q;
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in)
			brk_run_q <= '0;
		else if (state_q != L_BREAK)
			brk_run_q <= '0;
		else if (brk_run_q != '1)
			brk_run_q <= brk_run_q + 1'b1;
	end
	property p_break_full;
		@(posedge ref_clk_in) disable iff (rst_in)
		$fell(state_q == L_BREAK) |-> brk_run_q == `TX_BREAK_CYCLES;
	endproperty
	a_break_full: assert property (p_break_full)
		else $error("error break length wrong");
	property p_frame;
		@(posedge ref_clk_in) disable iff (rst_in)
		frame_err |=> (state_q == L_BREAK) && err_q;
	endproperty
	a_frame: assert property (p_frame)
		else $error("framing error not handled");
	property p_collide;
		@(posedge ref_clk_in) disable iff (rst_in)
		collide |=> state_q == L_BREAK;
	endproperty
	a_collide: assert property (p_collide)
		else $error("collision not handled");
	property p_waithi;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == L_WAITHI && !line_hi) |=> state_q == L_WAITHI;
	endproperty
	a_waithi: assert property (p_waithi)
		else $error("left break hold while pin low");
	property p_nodrive;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == L_RX) |=> !drive_q;
	endproperty
	a_nodrive: assert property (p_nodrive)
		else $error("drove pin while receiving");
	property p_relearn;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == L_WAITHI) |=> period_q == '0;
	endproperty
	a_relearn: assert property (p_relearn)
		else $error("baud not cleared after break");
	property p_drive_only;
		@(posedge ref_clk_in) disable iff (rst_in)
		!(state_q == L_TX || state_q == L_BREAK) |=> !drive_q;
	endproperty
	a_drive_only: assert property (p_drive_only)
		else $error("pin driven outside send or break");
	property p_sync_lock;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == L_SYNC && line_hi) |=> state_q == L_READY;
	endproperty
	a_sync_lock: assert property (p_sync_lock)
		else $error("sync end did not lock the rate");
	property p_flush;
		@(posedge ref_clk_in) disable iff (rst_in)
		err_q |=> !fifo_valid;
	endproperty
	a_flush: assert property (p_flush)
		else $error("queued bytes kept after an error");
	property p_rx_frame;
		@(posedge ref_clk_in) disable iff (rst_in)
		(state_q == L_RX && bit_q == 4'h9 && cnt_q == half(period_q) &&
			line_hi) |=> rxv_q;
	endproperty
	a_rx_frame: assert property (p_rx_frame)
		else $error("good character not delivered");
	property p_stop_reset;
		@(posedge ref_clk_in) disable iff (rst_in)
		(stop_mode_in && !line_hi) |=> sys_reset_req_out;
	endproperty
	a_stop_reset: assert property (p_stop_reset)
		else $error("pin low in stop mode gave no reset request");
endmodule

// [verif/debug_host_model.sv]
/*
 * behavioural host at the far side of the one-pin debug link.
 * assumes an external pull-up, so a released line reads high.
 */
`timescale 1ns/1ps
module debug_host_model #(
	parameter int P = 16
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic pull_low_out
);
	initial pull_low_out = 1'b0;

	// open drain, pull low at any time
	task automatic drive(input logic lvl, input int n);
		pull_low_out <= !lvl;
		repeat (n) @(posedge clk_in);
	endtask

	// framed character at clock over 16
	task automatic send(input logic [7:0] b, input logic stop);
		drive(1'b0, P);
		for (int i = 0; i < 8; i++) begin
			drive(b[i], P);
		end
		drive(stop, P);
		drive(1'b1, P);
	endtask

	// receive one character, sampling mid-bit; ok low on timeout or bad stop
	task automatic get(output logic [7:0] b, output logic ok);
		int t;
		t = 0;
		while (line_in && t < 2000) begin
			@(posedge clk_in);
			t++;
		end
		ok = !line_in;
		repeat (P / 2) @(posedge clk_in);
		for (int i = 0; i < 8; i++) begin
			repeat (P) @(posedge clk_in);
			b[i] = line_in;
		end
		repeat (P) @(posedge clk_in);
		ok = ok & line_in;
	endtask

	// pull low over a device character k cycles after its start
	task automatic clash(input int k);
		while (line_in) @(posedge clk_in);
		repeat (k) @(posedge clk_in);
		drive(1'b0, P);
		pull_low_out <= 1'b0;
	endtask
endmodule

// [verif/debug_serial_link_tb.sv]
/*
 * self-checking testbench for the one-pin debug serial link.
 * assumes the host model and a pull-up on the shared pin.
 */
`timescale 1ns/1ps
module debug_serial_link_tb;
	import debug_link_pkg::*;
	localparam int P = 16;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic rx_ready_in = 1'b0;
	byte_t tx_data_in = 8'h00;
	logic tx_valid_in = 1'b0;
	logic [4:0] ev = 5'h00;
	logic pc_en = 1'b0;
	logic zen = 1'b0;
	logic stop_in = 1'b0;
	logic [15:0] pc = 16'h0000;
	logic [15:0] cnt = 16'h0000;
	logic dout, oe, rxv, txr, err, lock, dbg, fst, hx, wdt, srst;
	logic [7:0] rxd;
	logic host_low, line;
	int n_errors = 0;
	int num_checks = 0;

	// open-drain wire: low if either side pulls
	assign line = !((oe && !dout) || host_low);
	always #25 ref_clk_in = !ref_clk_in;

	debug_host_model #(.P(P)) host (.clk_in(ref_clk_in), .line_in(line),
		.pull_low_out(host_low));

	debug_serial_link dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.debug_serial_pin_in(line), .debug_serial_pin_out(dout),
		.debug_serial_pin_oe_out(oe), .rx_data_out(rxd),
		.rx_valid_out(rxv), .rx_ready_in(rx_ready_in),
		.tx_data_in(tx_data_in), .tx_valid_in(tx_valid_in),
		.tx_ready_out(txr), .error_out(err), .baud_locked_out(lock),
		.set_mode_in(ev[0]), .clr_mode_in(ev[1]),
		.breakpoint_instruction_in(ev[2]), .pc_match_en_in(pc_en),
		.pc_in(pc), .debug_multi_counter_in(cnt), .cntr_zero_en_in(zen),
		.cntr_dec_in(ev[3]), .dev_reset_in(ev[4]), .stop_mode_in(stop_in),
		.debug_mode_out(dbg), .fetch_stop_out(fst), .halt_exit_out(hx),
		.wdt_refresh_out(wdt), .sys_reset_req_out(srst));

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
	endtask

	task automatic chk(input string nm, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic resync;
		host.send(8'h80, 1'b1);
		cyc(3);
		chk("baud_locked", 16'(lock), 16'h1);
	endtask

	// wait for the error pulse, time the returned break, then relearn
	task automatic see_error;
		int t;
		t = 0;
		while (!err && t < 600) begin
			cyc(1);
			t++;
		end
		chk("error_pulse", 16'(err), 16'h1);
		t = 0;
		while (!oe && t < 8) begin
			cyc(1);
			t++;
		end
		t = 0;
		while (oe && t < 5000) begin
			cyc(1);
			t++;
		end
		chk("break_len", 16'(t), 16'h1000);
		cyc(2);
		chk("baud_reset", 16'(lock), 16'h0);
		resync();
	endtask

	// received byte is held until accepted
	task automatic t_rx;
		int t;
		host.send(8'h35, 1'b1);
		t = 0;
		while (!rxv && t < 100) begin
			cyc(1);
			t++;
		end
		chk("rx_data", 16'(rxd), 16'h0035);
		cyc(5);
		chk("rx_hold", 16'(rxv), 16'h1);
		rx_ready_in <= 1'b1;
		cyc(1);
		rx_ready_in <= 1'b0;
		cyc(2);
		chk("rx_taken", 16'(rxv), 16'h0);
	endtask

	// fill the transmit fifo until it refuses, check bytes in order
	task automatic t_tx;
		logic [7:0] sent[$];
		logic [7:0] got[$];
		logic [7:0] b;
		logic ok;
		logic full;
		full = 1'b0;
		fork
			for (int i = 0; i < 7; i++) begin
				if (txr) begin
					tx_data_in <= 8'h10 + 8'(i);
					tx_valid_in <= 1'b1;
					sent.push_back(8'h10 + 8'(i));
					cyc(1);
					tx_valid_in <= 1'b0;
					cyc(2);
				end else begin
					full = 1'b1;
					cyc(3);
				end
			end
			begin
				ok = 1'b1;
				while (ok) begin
					host.get(b, ok);
					if (ok) got.push_back(b);
				end
			end
		join
		chk("fifo_full", 16'(full), 16'h1);
		chk("tx_count", 16'(got.size()), 16'(sent.size()));
		for (int i = 0; i < got.size(); i++) begin
			chk("tx_byte", 16'(got[i]), 16'(sent[i]));
		end
	endtask

	task automatic t_frame;
		fork
			host.send(8'h55, 1'b0);
			see_error();
		join
	endtask

	task automatic t_coll;
		tx_data_in <= 8'hff;
		tx_valid_in <= 1'b1;
		cyc(1);
		tx_valid_in <= 1'b0;
		fork
			host.clash(2 * P);
			see_error();
		join
	endtask

	task automatic fire(input logic [4:0] e, input logic x);
		ev <= e;
		cyc(1);
		ev <= 5'h00;
		cyc(3);
		chk("debug_mode", 16'(dbg), 16'(x));
	endtask

	// every entry and exit cause of debug mode except the pin strap entry
	task automatic t_mode;
		fire(5'h01, 1'b1);
		chk("cpu_hold", 16'({fst, hx, wdt}), 16'h7);
		fire(5'h02, 1'b0);
		chk("cpu_hold", 16'({fst, hx, wdt}), 16'h0);
		fire(5'h04, 1'b1);
		fire(5'h10, 1'b0);
		pc <= 16'h1234;
		cnt <= 16'h1234;
		fire(5'h00, 1'b0);
		pc_en <= 1'b1;
		fire(5'h00, 1'b1);
		pc_en <= 1'b0;
		fire(5'h02, 1'b0);
		cnt <= 16'h0001;
		zen <= 1'b1;
		fire(5'h08, 1'b1);
		zen <= 1'b0;
		fire(5'h10, 1'b0);
	endtask

	// host break while in debug mode
	task automatic t_break;
		fire(5'h01, 1'b1);
		fork
			begin
				host.drive(1'b0, 12 * P);
				host.drive(1'b1, P);
			end
			see_error();
		join
		chk("mode_kept", 16'(dbg), 16'h1);
	endtask

	task automatic t_strap;
		stop_in <= 1'b1;
		host.drive(1'b0, 20);
		chk("sys_reset_req", 16'(srst), 16'h1);
		stop_in <= 1'b0;
		rst_in <= 1'b1;
		cyc(3);
		rst_in <= 1'b0;
		cyc(4);
		chk("strap_entry", 16'(dbg), 16'h1);
		host.drive(1'b1, 4);
	endtask

	// main sequence
	initial begin
		cyc(12);
		rst_in <= 1'b0;
		cyc(4);
		chk("idle_lock", 16'({lock, oe, dbg}), 16'h0);
		resync();
		t_rx();
		t_tx();
		t_frame();
		t_coll();
		t_mode();
		t_break();
		t_strap();
		conclude();
	end

	// watchdog against a hang
	initial begin
		cyc(60000);
		n_errors++;
		conclude();
	end
endmodule
